// *** design/scp_defs.vh ***
// Constants for the system clock, prescaler and PLL control block
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCP_OFF_TRIM        12'h000
`define SCP_OFF_PRESCALE    12'h004
`define SCP_OFF_PLL         12'h008
`define SCP_OFF_STATUS      12'h00C

// ****************************************************************
// Field positions
// ****************************************************************
`define SCP_TRIM_BAND_BIT   7
`define SCP_PRE_UNLOCK_BIT  7
`define SCP_PRE_DIV_MSB     3
`define SCP_PRE_DIV_LSB     0
`define SCP_PLL_DIV_MSB     4
`define SCP_PLL_DIV_LSB     2
`define SCP_PLL_ON_BIT      1
`define SCP_PLL_LOCK_BIT    0
`define SCP_STAT_START_BIT  0
`define SCP_STAT_PEND_BIT   1

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define SCP_DIV_RST_FUSE    4'h3
`define SCP_DIV_RST_NOFUSE  4'h0
`define SCP_DIV_MAX         4'h8
`define SCP_PLL_DIV_RST     3'h0
`define SCP_PLL_DIV_BY2     3'h1
`define SCP_SUT_NONE        2'h0
`define SCP_SUT_SHORT       2'h1
`define SCP_SUT_LONG        2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define SCP_CLK_PERIOD_NS   5
`define SCP_UNLOCK_CYC      3'h4
`define SCP_RESET_CK        14
`define SCP_WAKE_CK         6
`define SCP_SHORT_DLY_NS    4100000
`define SCP_LONG_DLY_NS     65000000
`define SCP_PLL_LOCK_NS     1000000
`define SCP_SHORT_DLY_CYC   (`SCP_SHORT_DLY_NS / `SCP_CLK_PERIOD_NS)
`define SCP_LONG_DLY_CYC    (`SCP_LONG_DLY_NS / `SCP_CLK_PERIOD_NS)
`define SCP_PLL_LOCK_CYC    (`SCP_PLL_LOCK_NS / `SCP_CLK_PERIOD_NS)

`endif

// *** design/scp_top.v ***
// System clock prescaler, RC trim, start-up timer and PLL control
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "scp_defs.vh"

// Summary of operation
// (R1) Reset loads the factory trim value into the oscillator trim register.
// (R2) Trim top bit selects low or high overlapping oscillator band.
// (R3) Lower seven trim bits tune frequency, zero lowest, all ones highest.
// (R4) Software keeps trim below the memory-write limit while writing memory.
// (R5) Start-up fuses give 6 cycles from sleep, 14 plus optional delay.
// (R6) External clock changes stay under two percent per cycle, else reset.
// (R7) Clock-output fuse drives system clock on the pin, overriding GPIO.
// (R8) Clock pin shows the clock after the system prescaler; at division 0000 the code holds the pin high instead.
// (R9) Prescaler divides all system clocks together and switches glitch-free.
// (R10) New division takes effect after one old and one or two new periods.
// (R11) Software writes unlock alone, then division within four cycles.
// (R12) Unlock bit sets only when all other prescale bits written zero.
// (R13) Unlock clears after four cycles or on division write; no extension.
// (R14) Software disables interrupts during the two-step prescaler change.
// (R15) Division resets to 0011 with divide-by-eight fuse, else 0000.
// (R16) Any division value is accepted through the unlock sequence.
// (R17) Division field gives two to the field value, up to 256.
// (R18) Prescale bits 6 to 4 always read zero.
// (R19) PLL multiplies its 8 MHz reference by six for the USB clock.
// (R20) PLL input divider code zero divides by one, code one by two.
// (R21) PLL enable starts PLL and RC reference; reads one if PLL is source.
// (R22) Lock flag sets once the PLL has locked after enable.
// (R23) RC oscillator start-up codes give the same delays as external clock.
// (R24) Lock flag is read-only and clears when the PLL is disabled.
module scp_top #(
    parameter [31:0] P_SHORT_DLY_CYC = `SCP_SHORT_DLY_CYC,
    parameter [31:0] P_LONG_DLY_CYC  = `SCP_LONG_DLY_CYC,
    parameter [31:0] P_PLL_LOCK_CYC  = `SCP_PLL_LOCK_CYC
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_b,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output wire        o_pready,
    output wire        o_pslverr,
    output reg  [31:0] o_prdata,
    // Fuses and calibration byte
    input  wire [7:0]  i_factory_trim,
    input  wire        i_divide_by_eight_fuse,
    input  wire        i_clock_output_fuse,
    input  wire [1:0]  i_startup_delay_fuses,
    // PLL and sleep status
    input  wire        i_pll_is_sysclk,
    input  wire        i_pll_lock_detect,
    input  wire        i_wake_req,
    // Oscillator trim
    output reg         o_trim_band_select,
    output reg  [6:0]  o_trim_fine_value,
    // System clock
    output wire        o_sys_clk_en,
    output reg  [3:0]  o_system_division_select,
    output reg         o_clock_output_pin,
    output reg         o_clock_output_oe,
    // PLL control
    output reg         o_pll_on,
    output reg         o_rc_osc_start,
    output reg  [2:0]  o_pll_input_divider,
    output reg         o_pll_ref_div2,
    output reg         o_pll_locked_flag,
    // Start-up
    output reg         o_startup_done,
    output reg         o_wake_ready
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    reg  [14:0] sync_a;
    reg  [14:0] sync_b;
    wire [7:0]  fz_trim;
    wire        fz_div8;
    wire        fz_clock_output_fuse;
    wire [1:0]  fz_sut;
    wire        s_pll_sys;
    wire        s_lock_det;
    wire        s_wake;
    reg         wake_q;

    always @(posedge i_clk) begin
        sync_a <= {i_wake_req, i_pll_lock_detect, i_pll_is_sysclk,
                   i_startup_delay_fuses, i_clock_output_fuse,
                   i_divide_by_eight_fuse, i_factory_trim};
        sync_b <= sync_a;
    end

    assign fz_trim    = sync_b[7:0];
    assign fz_div8    = sync_b[8];
    assign fz_clock_output_fuse   = sync_b[9];
    assign fz_sut     = sync_b[11:10];
    assign s_pll_sys  = sync_b[12];
    assign s_lock_det = sync_b[13];
    assign s_wake     = sync_b[14];

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire acc      = i_psel & i_penable;
    wire wr       = acc & i_pwrite;
    wire hit_trim = (i_paddr == `SCP_OFF_TRIM);
    wire hit_pre  = (i_paddr == `SCP_OFF_PRESCALE);
    wire hit_pll  = (i_paddr == `SCP_OFF_PLL);
    wire hit_stat = (i_paddr == `SCP_OFF_STATUS);
    wire mapped   = hit_trim | hit_pre | hit_pll | hit_stat;

    assign o_pready  = 1'b1;
    assign o_pslverr = acc & ~mapped;

    // ****************************************************************
    // Oscillator trim
    // ****************************************************************
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_trim_band_select <= fz_trim[`SCP_TRIM_BAND_BIT]; // R1
            o_trim_fine_value  <= fz_trim[6:0]; // R1
        end else if (wr && hit_trim) begin
            o_trim_band_select <= i_pwdata[`SCP_TRIM_BAND_BIT]; // R2
            o_trim_fine_value  <= i_pwdata[6:0]; // R3
        end
    end

    // ****************************************************************
    // Prescaler unlock sequence
    // ****************************************************************
    reg        unlock;
    reg  [2:0] unlock_cnt;
    reg  [3:0] pend_div;
    reg        pend_valid;
    wire       unlock_wr = wr && hit_pre &&
                           i_pwdata[`SCP_PRE_UNLOCK_BIT] &&
                           (i_pwdata[6:0] == 7'h00); // R12
    wire       div_wr    = wr && hit_pre && unlock &&
                           !i_pwdata[`SCP_PRE_UNLOCK_BIT]; // R11
    wire       tick;

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            unlock     <= 1'b0;
            unlock_cnt <= 3'h0;
        end else if (div_wr) begin
            unlock     <= 1'b0; // R13
            unlock_cnt <= 3'h0;
        end else if (unlock_wr && !unlock) begin
            unlock     <= 1'b1; // R12
            unlock_cnt <= `SCP_UNLOCK_CYC;
        end else if (unlock) begin
            unlock_cnt <= unlock_cnt - 3'h1; // R13
            if (unlock_cnt == 3'h1) begin
                unlock <= 1'b0; // R13
            end
        end
    end

    // ****************************************************************
    // Glitch-free power-of-two divider
    // ****************************************************************
    reg  [7:0] div_cnt;
    reg        run_prev;
    wire [3:0] eff_div = (o_system_division_select > `SCP_DIV_MAX) ?
                         `SCP_DIV_MAX : o_system_division_select; // R17
    wire [8:0] mask9   = (9'h001 << eff_div) - 9'h001; // R17
    wire [7:0] mask    = mask9[7:0];
    wire [7:0] next_cnt;

    assign tick         = ((div_cnt & mask) == mask);
    assign o_sys_clk_en = tick; // R9
    assign next_cnt     = (tick && pend_valid) ? 8'h00 : div_cnt + 8'h01;

    always @(posedge i_clk) begin
        run_prev <= i_rst_b;
        if (!i_rst_b) begin
            o_system_division_select <= fz_div8 ? `SCP_DIV_RST_FUSE :
                                        `SCP_DIV_RST_NOFUSE; // R15
            pend_div   <= 4'h0;
            pend_valid <= 1'b0;
            // Cleared on reset entry, then runs on so the pin keeps toggling
            if (!run_prev) begin
                div_cnt <= next_cnt; // R7
            end else begin
                div_cnt <= 8'h00;
            end
        end else begin
            div_cnt <= next_cnt;
            if (tick && pend_valid) begin
                // Switch only at an old-period boundary
                o_system_division_select <= pend_div; // R10
                pend_valid <= div_wr; // R9
            end
            if (div_wr) begin
                pend_div   <= i_pwdata[`SCP_PRE_DIV_MSB:`SCP_PRE_DIV_LSB]; // R16
                pend_valid <= 1'b1; // R10
            end
        end
    end

    // ****************************************************************
    // Clock output pin
    // ****************************************************************
    wire [7:0] half     = mask >> 1;
    wire [7:0] next_ph  = (tick && pend_valid) ? 8'h00 : (next_cnt & mask);

    always @(posedge i_clk) begin
        // Pin keeps running through reset
        o_clock_output_oe  <= fz_clock_output_fuse; // R7
        o_clock_output_pin <= fz_clock_output_fuse &
                              ((mask == 8'h00) | (next_ph <= half)); // R7 R8
    end

    // ****************************************************************
    // PLL control
    // ****************************************************************
    reg         pll_en;
    reg  [31:0] lock_cnt;
    wire        pll_run = pll_en | s_pll_sys; // R21

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            pll_en              <= 1'b0;
            o_pll_input_divider <= `SCP_PLL_DIV_RST;
        end else if (wr && hit_pll) begin
            pll_en              <= i_pwdata[`SCP_PLL_ON_BIT]; // R21
            o_pll_input_divider <=
                i_pwdata[`SCP_PLL_DIV_MSB:`SCP_PLL_DIV_LSB]; // R20
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_pll_on          <= 1'b0;
            o_rc_osc_start    <= 1'b0;
            o_pll_ref_div2    <= 1'b0;
            o_pll_locked_flag <= 1'b0;
            lock_cnt          <= 32'h0000_0000;
        end else begin
            o_pll_on       <= pll_run; // R19
            o_rc_osc_start <= pll_run; // R21
            o_pll_ref_div2 <= (o_pll_input_divider ==
                               `SCP_PLL_DIV_BY2); // R20
            if (!pll_run || !s_lock_det) begin
                lock_cnt          <= 32'h0000_0000;
                o_pll_locked_flag <= 1'b0; // R24
            end else if (lock_cnt < P_PLL_LOCK_CYC) begin
                lock_cnt <= lock_cnt + 32'h0000_0001;
            end else begin
                o_pll_locked_flag <= 1'b1; // R22
            end
        end
    end

    // ****************************************************************
    // Start-up and wake delays
    // ****************************************************************
    reg  [31:0] st_cnt;
    reg  [31:0] st_target;
    reg  [2:0]  wk_cnt;
    reg         wk_busy;

    always @* begin
        case (fz_sut)
            `SCP_SUT_NONE:  st_target = `SCP_RESET_CK;
            `SCP_SUT_SHORT: st_target = `SCP_RESET_CK + P_SHORT_DLY_CYC;
            `SCP_SUT_LONG:  st_target = `SCP_RESET_CK + P_LONG_DLY_CYC;
            default:        st_target = `SCP_RESET_CK + P_LONG_DLY_CYC;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_cnt         <= 32'h0000_0000;
            o_startup_done <= 1'b0;
        end else if (!o_startup_done) begin
            st_cnt <= st_cnt + 32'h0000_0001;
            if (st_cnt + 32'h0000_0001 >= st_target) begin
                o_startup_done <= 1'b1; // R5 R23
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            wake_q       <= 1'b0;
            wk_cnt       <= 3'h0;
            wk_busy      <= 1'b0;
            o_wake_ready <= 1'b0;
        end else begin
            wake_q       <= s_wake;
            o_wake_ready <= 1'b0;
            if (s_wake && !wake_q && !wk_busy) begin
                wk_busy <= 1'b1;
                wk_cnt  <= 3'h1;
            end else if (wk_busy) begin
                wk_cnt <= wk_cnt + 3'h1;
                if (wk_cnt == `SCP_WAKE_CK) begin
                    wk_busy      <= 1'b0; // R5 R23
                    o_wake_ready <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always @* begin
        o_prdata = 32'h0000_0000;
        if (acc && !i_pwrite) begin
            if (hit_trim) begin
                o_prdata[7:0] = {o_trim_band_select, o_trim_fine_value};
            end else if (hit_pre) begin
                o_prdata[`SCP_PRE_UNLOCK_BIT] = unlock;
                o_prdata[3:0] = o_system_division_select; // R18
            end else if (hit_pll) begin
                o_prdata[`SCP_PLL_DIV_MSB:`SCP_PLL_DIV_LSB] =
                    o_pll_input_divider;
                o_prdata[`SCP_PLL_ON_BIT]   = pll_run; // R21
                o_prdata[`SCP_PLL_LOCK_BIT] = o_pll_locked_flag; // R24
            end else if (hit_stat) begin
                o_prdata[`SCP_STAT_START_BIT] = o_startup_done;
                o_prdata[`SCP_STAT_PEND_BIT]  = pend_valid;
            end
        end
    end

endmodule // scp_top

// *** verif/scp_top_asserts.sv ***
// Checker module and bind for the clock prescaler and PLL control block
`timescale 1ns/1ps
module scp_chk (
    // Clock, reset and APB
    input wire        i_clk, i_rst_b, i_psel, i_penable, i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata, o_prdata,
    input wire        o_pslverr, o_sys_clk_en, i_divide_by_eight_fuse,
    // Trim, clock output and PLL
    input wire [7:0]  i_factory_trim,
    input wire [6:0]  o_trim_fine_value,
    input wire [3:0]  o_system_division_select,
    input wire        o_trim_band_select, i_clock_output_fuse,
    input wire        o_clock_output_oe, o_clock_output_pin,
    input wire        i_pll_is_sysclk, o_pll_on, o_rc_osc_start,
    input wire        o_pll_locked_flag
);
    wire       pre = i_psel && i_penable && i_paddr == 12'h004;
    wire [3:0] dv  = o_system_division_select;
    reg  [2:0] ucnt;
    // ****************************************
    // Unlock window tracker
    // ****************************************
    always @(posedge i_clk) begin
        if (!i_rst_b)
            ucnt <= 3'h0;
        else if (pre && i_pwrite && ucnt == 3'h0 && i_pwdata[7:0] == 8'h80)
            ucnt <= 3'h4;
        else if (pre && i_pwrite && ucnt != 3'h0 && !i_pwdata[7])
            ucnt <= 3'h0;
        else if (ucnt != 3'h0)
            ucnt <= ucnt - 3'h1;
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_trim_reset_load: assert property ($rose(i_rst_b) |->
        {o_trim_band_select, o_trim_fine_value} == i_factory_trim)
        else $error("trim not loaded at reset");
    a_div_reset_value: assert property ($rose(i_rst_b) |->
        dv == (i_divide_by_eight_fuse ? 4'h3 : 4'h0))
        else $error("division reset value wrong");
    a_unlock_window: assert property (pre && !i_pwrite |->
        o_prdata[7] == (ucnt != 3'h0)) else $error("unlock bit wrong");
    a_prescale_rsvd: assert property (pre && !i_pwrite |->
        o_prdata[31:8] == 24'h0 && o_prdata[6:4] == 3'h0)
        else $error("reserved prescale bits set");
    a_clkout_enable: assert property (o_clock_output_oe ==
        i_clock_output_fuse) else $error("clock pin enable wrong");
    a_div_one_tick: assert property (dv == 4'h0 && $past(dv) == 4'h0
        |-> o_sys_clk_en) else $error("missing tick at divide by one");
    a_div_two_gap: assert property (o_sys_clk_en && dv == 4'h1
        && $past(dv) == 4'h1 ##1 dv == 4'h1 |-> !o_sys_clk_en)
        else $error("tick too soon at divide by two");
    a_pin_divided: assert property (o_clock_output_oe && dv == 4'h1
        && $past(dv, 3) == 4'h1 |-> o_clock_output_pin !=
        $past(o_clock_output_pin)) else $error("clock pin not divided");
    a_pll_forced_on: assert property (i_pll_is_sysclk[*3] |=>
        o_pll_on && o_rc_osc_start) else $error("pll not forced on");
    a_lock_clears: assert property (!o_pll_on |=>
        !o_pll_locked_flag) else $error("lock flag stays set");
    a_unmapped_err: assert property (i_psel && i_penable &&
        i_paddr > 12'h00C |-> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    cover property (o_pll_locked_flag);
    cover property (pre && i_pwrite && ucnt != 3'h0);
    cover property (dv == 4'h8);
endmodule // scp_chk

bind scp_top scp_chk u_chk (
    .i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pslverr, .o_sys_clk_en, .i_divide_by_eight_fuse,
    .i_factory_trim, .o_trim_fine_value, .o_system_division_select,
    .o_trim_band_select, .i_clock_output_fuse, .o_clock_output_oe,
    .o_clock_output_pin, .i_pll_is_sysclk, .o_pll_on, .o_rc_osc_start,
    .o_pll_locked_flag
);

// *** verif/scp_pll_model.sv ***
// Behavioural analog PLL giving a lock indication after settling
`timescale 1ns/1ps
module scp_pll_model #(
    parameter int P_SETTLE = 20
) (
    // Clock and enable from the block
    input  wire  i_clk,
    input  wire  i_pll_on,
    // Lock indication to the block
    output logic o_lock_detect = 1'b0
);
    int cnt = 0;
    // Lock only after settling; drops at once when disabled
    always @(posedge i_clk) begin
        if (!i_pll_on) begin
            cnt <= 0;
            o_lock_detect <= 1'b0;
        end else if (cnt < P_SETTLE) begin
            cnt <= cnt + 1;
        end else begin
            o_lock_detect <= 1'b1;
        end
    end
endmodule // scp_pll_model

// *** verif/tb_top.sv ***
// Self-checking bench for the clock prescaler and PLL control block
`timescale 1ns/1ps
module tb_top;
    logic        i_clk = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0;
    logic        i_penable = 1'b0, i_pwrite = 1'b0, i_wake_req = 1'b0;
    logic        i_pll_is_sysclk = 1'b0, er;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000, rd;
    logic [1:0]  i_startup_delay_fuses = 2'h0;
    logic [7:0]  i_factory_trim = 8'h5A;
    logic        i_divide_by_eight_fuse = 1'b1, i_clock_output_fuse = 1'b1;
    wire         i_pll_lock_detect, o_pready, o_pslverr, o_sys_clk_en;
    wire         o_trim_band_select, o_clock_output_pin, o_clock_output_oe;
    wire         o_pll_on, o_rc_osc_start, o_pll_ref_div2, o_pll_locked_flag;
    wire         o_startup_done, o_wake_ready;
    wire [31:0]  o_prdata;
    wire [6:0]   o_trim_fine_value;
    wire [3:0]   o_system_division_select;
    wire [2:0]   o_pll_input_divider;
    int          failures = 0, comparisons = 0, cycles = 0;
    scp_top #(.P_SHORT_DLY_CYC(20), .P_LONG_DLY_CYC(40),
        .P_PLL_LOCK_CYC(10)) u_dut (.i_clk, .i_rst_b, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_prdata,
        .i_factory_trim, .i_divide_by_eight_fuse, .i_clock_output_fuse,
        .i_startup_delay_fuses, .i_pll_is_sysclk, .i_pll_lock_detect,
        .i_wake_req, .o_trim_band_select, .o_trim_fine_value, .o_sys_clk_en,
        .o_system_division_select, .o_clock_output_pin, .o_clock_output_oe,
        .o_pll_on, .o_rc_osc_start, .o_pll_input_divider, .o_pll_ref_div2,
        .o_pll_locked_flag, .o_startup_done, .o_wake_ready);
    scp_pll_model u_pll (.i_clk, .i_pll_on(o_pll_on),
        .o_lock_detect(i_pll_lock_detect));
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            complete_run;
        end
    end
    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        chk(n, e, rd);
    endtask
    task wait_lo(output int n, input logic [3:0] c, input int lim);
        for (n = 1; n < lim; n++) begin
            @(negedge i_clk);
            if (o_system_division_select === c && o_sys_clk_en === 1'b1) break;
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset_trim;
        rdchk("trim", 12'h000, 32'h0000_005A);
        rdchk("prescale", 12'h004, 32'h0000_0003);
        chk("clock pin enable", 32'h1, o_clock_output_oe);
        apb(12'h000, 1'b1, 32'h0000_007F);
        @(negedge i_clk);
        chk("trim out", 32'h7F, {o_trim_band_select, o_trim_fine_value});
        apb(12'h000, 1'b1, 32'h0000_0080);
        @(negedge i_clk);
        chk("band", 32'h1, o_trim_band_select);
        rdchk("trim", 12'h000, 32'h0000_0080);
    endtask
    task t_unlock;
        apb(12'h004, 1'b1, 32'h0000_0081);
        apb(12'h004, 1'b1, 32'h0000_0005);
        apb(12'h004, 1'b1, 32'h0000_0080);
        apb(12'h004, 1'b1, 32'h0000_0080);
        rdchk("prescale", 12'h004, 32'h0000_0003);
        apb(12'h004, 1'b1, 32'h0000_0005);
        repeat (20) @(posedge i_clk);
        chk("division", 32'h3, o_system_division_select);
    endtask
    task t_div;
        int t;
        int n;
        int old;
        int nw;
        old = 8;
        for (int c = 0; c < 10; c++) begin
            nw = (c > 8) ? 256 : (1 << c);
            apb(12'h004, 1'b1, 32'h0000_0080);
            apb(12'h004, 1'b1, 32'(c));
            wait_lo(t, 4'(c), 2000);
            chk("switch time", 32'h1, t >= nw && t <= old + 2 * nw);
            wait_lo(n, 4'(c), 600);
            chk("period", 32'(nw), 32'(n));
            rdchk("prescale", 12'h004, 32'(c));
            old = nw;
        end
    endtask
    task t_pll;
        int n;
        apb(12'h008, 1'b1, 32'h0000_0006);
        repeat (2) @(posedge i_clk);
        chk("pll path", 32'h39, {o_pll_ref_div2, o_pll_on, o_rc_osc_start,
            o_pll_input_divider});
        rdchk("pll", 12'h008, 32'h0000_0006);
        for (n = 0; n < 200 && o_pll_locked_flag !== 1'b1; n++)
            @(posedge i_clk);
        rdchk("pll", 12'h008, 32'h0000_0007);
        apb(12'h008, 1'b1, 32'h0000_0005);
        repeat (3) @(posedge i_clk);
        rdchk("pll", 12'h008, 32'h0000_0004);
        i_pll_is_sysclk <= 1'b1;
        repeat (2) @(posedge i_clk);
        rdchk("pll", 12'h008, 32'h0000_0006);
        i_pll_is_sysclk <= 1'b0;
        apb(12'h010, 1'b1, 32'h0000_00FF);
        chk("slave error", 32'h1, er);
        rdchk("unmapped", 12'h010, 32'h0000_0000);
    endtask
    task t_start;
        int n;
        @(posedge i_clk);
        i_wake_req <= 1'b1;
        for (n = 0; n < 30 && o_wake_ready !== 1'b1; n++) @(negedge i_clk);
        chk("wake time", 32'h1, n >= 7 && n <= 12);
        @(posedge i_clk);
        i_wake_req <= 1'b0;
        for (int c = 0; c < 3; c++) begin
            i_startup_delay_fuses <= 2'(c);
            i_rst_b <= 1'b0;
            n = 0;
            repeat (8) begin
                @(negedge i_clk);
                n += o_clock_output_pin;
            end
            chk("pin in reset", 32'h1, n > 0 && n < 8);
            @(posedge i_clk);
            i_rst_b <= 1'b1;
            for (n = 0; n < 200 && o_startup_done !== 1'b1; n++)
                @(negedge i_clk);
            chk("start time", 32'h1, n >= 14 + 20 * c &&
                n <= 17 + 20 * c);
            rdchk("status", 12'h00C, 32'h0000_0001);
            rdchk("trim", 12'h000, 32'h0000_005A);
        end
    endtask
    task complete_run;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_reset_trim;
        t_unlock;
        t_div;
        t_pll;
        t_start;
        complete_run;
    end
endmodule // tb_top
